// File: spf_defs.svh
`ifndef SPF_DEFS_SVH
`define SPF_DEFS_SVH

`define SPF_NUM_SECT        11
`define SPF_OP_RD_PROT      8'h3c
`define SPF_OP_RD_STAT      8'h05
`define SPF_OP_WR_STAT      8'h01
`define SPF_OP_PROTECT      8'h36
`define SPF_OP_UNPROTECT    8'h39
`define SPF_OP_WR_EN        8'h06
`define SPF_OP_WR_DIS       8'h04
`define SPF_ST_LOCK_BIT     7
`define SPF_ST_SEQ_BIT      6
`define SPF_ST_RSV_BIT      5
`define SPF_ST_PIN_BIT      4
`define SPF_ST_SUM_HI       3
`define SPF_ST_SUM_LO       2
`define SPF_ST_WEL_BIT      1
`define SPF_ST_BUSY_BIT     0
`define SPF_SUM_NONE        2'h0
`define SPF_SUM_SOME        2'h1
`define SPF_SUM_ALL         2'h3
`define SPF_BYTE_ON         8'hff
`define SPF_BYTE_OFF        8'h00
`define SPF_ADDR_BYTES      3'h3

`endif

// File: spf_pkg.sv
`default_nettype none
package spf_pkg;
  typedef enum logic [2:0] {
    SPF_IDLE   = 3'b000,
    SPF_OPCODE = 3'b001,
    SPF_ADDR   = 3'b011,
    SPF_DATA   = 3'b010,
    SPF_SHIFT  = 3'b110,
    SPF_IGNORE = 3'b111
  } spf_state_t;

  typedef struct packed {
    logic       seq_mode;
    logic       busy;
    logic       write_enable_latch;
  } spf_core_stat_t;

  typedef struct packed {
    logic       cs_n;
    logic       sck;
    logic       si;
    logic       wp_n;
  } spf_pins_t;
endpackage : spf_pkg
`default_nettype wire

// File: spf_prot_mem.sv
`default_nettype none
`include "spf_defs.svh"
module spf_prot_mem
  import spf_pkg::*;
(
  input  wire logic                      ref_clk_in,
  input  wire logic                      srst_in,
  input  wire logic                      wr_en_in,
  input  wire logic [3:0]                wr_idx_in,
  input  wire logic                      wr_val_in,
  input  wire logic [3:0]                rd_idx_in,
  output logic                           rd_val_out,
  output logic [`SPF_NUM_SECT-1:0]       bits_out
);
  logic [`SPF_NUM_SECT-1:0] prot_reg;

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
      prot_reg <= '1;
    else if (wr_en_in && wr_idx_in < 4'(`SPF_NUM_SECT))
      prot_reg[wr_idx_in] <= wr_val_in;
  end

  // Read data registered so the shifter sees a stable value
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
      rd_val_out <= 1'b1;
    else
      rd_val_out <= (rd_idx_in < 4'(`SPF_NUM_SECT)) ? prot_reg[rd_idx_in] : 1'b1;
  end

  assign bits_out = prot_reg;
endmodule : spf_prot_mem
`default_nettype wire

// File: spf_protect_core.sv
`default_nettype none
`include "spf_defs.svh"
module spf_protect_core
  import spf_pkg::*;
(
  input  wire logic                      ref_clk_in,
  input  wire logic                      srst_in,
  input  wire logic                      cs_n_in,
  input  wire logic                      sck_in,
  input  wire logic                      si_in,
  input  wire logic                      wp_n_in,
  input  wire spf_pkg::spf_core_stat_t   core_stat_in,
  output logic                           so_out,
  output logic                           so_oe_n_out,
  output logic                           wel_clr_out,
  output logic                           wel_set_out,
  output logic [7:0]                     status_out,
  output logic [`SPF_NUM_SECT-1:0]       sect_prot_out
);
  import spf_pkg::*;

  // Map a 24-bit address to a sector index (top-boot layout)
  function automatic logic [3:0] sect_of(input logic [23:0] a);
    logic [3:0] s;
    s = 4'(a[18:16]);
    if (a[18:16] == 3'h7)
    begin
      if (a[15] == 1'b0)
        s = 4'h7;
      else if (a[14] == 1'b1)
        s = 4'ha;
      else if (a[13] == 1'b0)
        s = 4'h8;
      else
        s = 4'h9;
    end
    return s;
  endfunction : sect_of

  // Two-stage synchronisers; only stage two is read
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic       sck_d_reg;
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      sync1_reg <= 4'hb;
      sync2_reg <= 4'hb;
      sck_d_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= {cs_n_in, sck_in, si_in, wp_n_in};
      sync2_reg <= sync1_reg;
      sck_d_reg <= sync2_reg[2];
    end
  end

  wire spf_pins_t pins = spf_pins_t'(sync2_reg);
  wire sck_rise = pins.sck & ~sck_d_reg & ~pins.cs_n;
  wire sck_fall = ~pins.sck & sck_d_reg & ~pins.cs_n;
  wire cs_act   = ~pins.cs_n;
  wire wp_asserted = ~pins.wp_n;

  logic                       lock_reg;
  logic                       lock_next;
  spf_state_t                 state_reg;
  spf_state_t                 state_next;
  logic [7:0]                 opc_reg;
  logic [23:0]                shin_reg;
  logic [2:0]                 bit_reg;
  logic [2:0]                 byte_reg;
  logic [7:0]                 sho_reg;
  logic                       so_reg;
  logic                       oe_reg;
  logic                       armed_reg;
  logic                       rd_bit;
  logic [`SPF_NUM_SECT-1:0]   prot_bits;

  wire       hw_locked = wp_asserted & lock_reg;
  wire [1:0] summary   = (&prot_bits) ? `SPF_SUM_ALL :
                         (|prot_bits) ? `SPF_SUM_SOME : `SPF_SUM_NONE;

  // Live status, reassembled combinationally every cycle
  assign status_out = {lock_reg,
                       core_stat_in.seq_mode,
                       1'b0,
                       pins.wp_n,
                       summary,
                       core_stat_in.write_enable_latch,
                       core_stat_in.busy};

  wire [7:0] opc_shift = {opc_reg[6:0], pins.si};
  wire [23:0] in_shift = {shin_reg[22:0], pins.si};
  wire byte_done = sck_rise && bit_reg == 3'h7;
  wire cs_end    = ~cs_act && state_reg != SPF_IDLE;
  wire full_cmd  = armed_reg;

  wire is_sector_op = opc_reg == `SPF_OP_PROTECT || opc_reg == `SPF_OP_UNPROTECT;
  wire is_wr_stat   = opc_reg == `SPF_OP_WR_STAT;
  // Sector ops need latch set and no lock of either kind
  wire sect_ok  = cs_end && is_sector_op && full_cmd && core_stat_in.write_enable_latch
                  && !lock_reg;
  wire stat_ok  = cs_end && is_wr_stat && full_cmd && core_stat_in.write_enable_latch
                  && !hw_locked
                  && !(wp_asserted && !shin_reg[`SPF_ST_LOCK_BIT]);
  // Any complete write-class opcode clears the latch on release
  wire wr_class = is_sector_op || is_wr_stat;
  assign wel_clr_out = cs_end && wr_class && opc_reg[7:0] != 8'h00
                       && state_reg != SPF_OPCODE;
  assign wel_set_out = cs_end && state_reg != SPF_OPCODE && opc_reg == `SPF_OP_WR_EN;

  always_comb
  begin
    lock_next = lock_reg;
    if (stat_ok)
      lock_next = shin_reg[`SPF_ST_LOCK_BIT];
  end

  spf_prot_mem u_mem (
    .ref_clk_in (ref_clk_in),
    .srst_in    (srst_in),
    .wr_en_in   (sect_ok),
    .wr_idx_in  (sect_of(shin_reg)),
    .wr_val_in  (opc_reg == `SPF_OP_PROTECT),
    .rd_idx_in  (sect_of(shin_reg)),
    .rd_val_out (rd_bit),
    .bits_out   (prot_bits)
  );

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      SPF_IDLE:
        if (cs_act)
          state_next = SPF_OPCODE;
      SPF_OPCODE:
        if (byte_done)
        begin
          if (opc_shift == `SPF_OP_RD_STAT)
            state_next = SPF_SHIFT;
          else if (opc_shift == `SPF_OP_RD_PROT || opc_shift == `SPF_OP_PROTECT
                   || opc_shift == `SPF_OP_UNPROTECT)
            state_next = SPF_ADDR;
          else if (opc_shift == `SPF_OP_WR_STAT)
            state_next = SPF_DATA;
          else
            state_next = SPF_IGNORE;
        end
      SPF_ADDR:
        if (byte_done && byte_reg == `SPF_ADDR_BYTES - 3'h1)
          state_next = (opc_reg == `SPF_OP_RD_PROT) ? SPF_SHIFT : SPF_IGNORE;
      SPF_DATA:
        if (byte_done)
          state_next = SPF_IGNORE;
      SPF_SHIFT:
        state_next = SPF_SHIFT;
      SPF_IGNORE:
        state_next = SPF_IGNORE;
      default:
        state_next = SPF_IDLE;
    endcase
    if (!cs_act)
      state_next = SPF_IDLE;
  end

  wire [7:0] rb_byte = rd_bit ? `SPF_BYTE_ON : `SPF_BYTE_OFF;
  wire       is_rdprot = opc_reg == `SPF_OP_RD_PROT;

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      state_reg <= SPF_IDLE;
      lock_reg  <= 1'b0;
      opc_reg   <= 8'h00;
      shin_reg  <= 24'h000000;
      bit_reg   <= 3'h0;
      byte_reg  <= 3'h0;
      armed_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      lock_reg  <= lock_next;
      if (!cs_act)
      begin
        bit_reg   <= 3'h0;
        byte_reg  <= 3'h0;
        armed_reg <= 1'b0;
        if (state_reg == SPF_IDLE)
          opc_reg <= 8'h00;
      end
      else if (sck_rise)
      begin
        bit_reg <= bit_reg + 3'h1;
        if (state_reg == SPF_OPCODE)
          opc_reg <= opc_shift;
        else if (state_reg == SPF_ADDR || state_reg == SPF_DATA)
          shin_reg <= in_shift;
        if (byte_done && state_reg != SPF_OPCODE)
          byte_reg <= byte_reg + 3'h1;
        if (byte_done && (state_reg == SPF_DATA
            || (state_reg == SPF_ADDR && byte_reg == `SPF_ADDR_BYTES - 3'h1)))
          armed_reg <= 1'b1;
      end
    end
  end

  // Output side: SPI mode 0/3, change on falling edge, fresh byte each wrap
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      sho_reg <= 8'h00;
      so_reg  <= 1'b0;
      oe_reg  <= 1'b0;
    end
    else if (!cs_act)
    begin
      oe_reg <= 1'b0;
      so_reg <= 1'b0;
    end
    else if (state_reg == SPF_SHIFT && sck_fall)
    begin
      oe_reg <= 1'b1;
      if (bit_reg == 3'h0)
      begin
        so_reg  <= is_rdprot ? rb_byte[7] : status_out[7];
        sho_reg <= is_rdprot ? {rb_byte[6:0], 1'b0} : {status_out[6:0], 1'b0};
      end
      else
      begin
        so_reg  <= sho_reg[7];
        sho_reg <= {sho_reg[6:0], 1'b0};
      end
    end
  end

  assign so_out        = so_reg;
  assign so_oe_n_out   = ~oe_reg;
  assign sect_prot_out = prot_bits;
endmodule : spf_protect_core
`default_nettype wire

// File: spf_protect_core_monitor.sv
`default_nettype none
`include "spf_defs.svh"
module spf_protect_core_monitor
  import spf_pkg::*;
(
  input wire logic                     ref_clk_in,
  input wire logic                     srst_in,
  input wire logic                     cs_n_in,
  input wire logic                     wp_n_in,
  input wire spf_pkg::spf_core_stat_t  core_stat_in,
  input wire logic                     so_oe_n_out,
  input wire logic                     wel_clr_out,
  input wire logic [7:0]               status_out,
  input wire logic [`SPF_NUM_SECT-1:0] sect_prot_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  property p_oe; cs_n_in [*5] |-> so_oe_n_out; endproperty
  a_oe: assert property (p_oe) else $error("output driven while deselected");
  property p_rsv; status_out[`SPF_ST_RSV_BIT] == 1'b0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved status bit set");
  property p_pin_hi; wp_n_in [*6] |-> status_out[`SPF_ST_PIN_BIT]; endproperty
  a_pin_hi: assert property (p_pin_hi) else $error("pin bit low with pin high");
  property p_pin_lo; (!wp_n_in) [*6] |-> !status_out[`SPF_ST_PIN_BIT]; endproperty
  a_pin_lo: assert property (p_pin_lo) else $error("pin bit high with pin low");
  property p_core;
    ($stable(core_stat_in)) [*2] |-> {status_out[6], status_out[1:0]}
      == {core_stat_in.seq_mode, core_stat_in.write_enable_latch, core_stat_in.busy};
  endproperty
  a_core: assert property (p_core) else $error("core status bits wrong");
  property p_sum;
    status_out[3:2] == (&sect_prot_out ? `SPF_SUM_ALL
                       : (|sect_prot_out ? `SPF_SUM_SOME : `SPF_SUM_NONE));
  endproperty
  a_sum: assert property (p_sum) else $error("summary field wrong");
  property p_lockhold; ((!wp_n_in) [*4] ##0 status_out[7]) |=> status_out[7]; endproperty
  a_lockhold: assert property (p_lockhold) else $error("lock cleared under pin");
  property p_freeze; status_out[7] |=> $stable(sect_prot_out); endproperty
  a_freeze: assert property (p_freeze) else $error("sector bits changed while locked");
  property p_wclr; wel_clr_out |-> cs_n_in ##1 !wel_clr_out; endproperty
  a_wclr: assert property (p_wclr) else $error("latch clear not a release pulse");
  property p_rst; $fell(srst_in) |-> (&sect_prot_out) && !status_out[7]; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  c_read: cover property (!so_oe_n_out);
  c_hwlock: cover property (status_out[7] && !wp_n_in);
  c_clr: cover property (wel_clr_out);
endmodule : spf_protect_core_monitor
bind spf_protect_core spf_protect_core_monitor u_mon (.ref_clk_in(ref_clk_in),
  .srst_in(srst_in), .cs_n_in(cs_n_in), .wp_n_in(wp_n_in), .core_stat_in(core_stat_in),
  .so_oe_n_out(so_oe_n_out), .wel_clr_out(wel_clr_out), .status_out(status_out),
  .sect_prot_out(sect_prot_out));
`default_nettype wire

// File: spf_host.sv
`default_nettype none
module spf_host
(
  input  wire logic so_in,
  input  wire logic so_oe_n_in,
  output logic      cs_n_out,
  output logic      sck_out,
  output logic      si_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released line must not pass for the last driven bit
  wire logic so_line = so_oe_n_in ? ~so_in : so_in;
  initial
  begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    si_out = 1'b0;
  end
  // Clock idles low between frames; bits go out MSB first, 48 ns per bit
  task automatic frame(input logic [31:0] tx, input int ntx, input int nrx,
                       output logic [15:0] rx);
    rx = 16'h0;
    cs_n_out = 1'b0;
    #24;
    for (int i = 0; i < ntx + nrx; i++)
    begin
      si_out = (i < ntx) ? tx[ntx-1-i] : 1'b0;
      #24 sck_out = 1'b1;
      if (i >= ntx) rx = {rx[14:0], so_line};
      #24 sck_out = 1'b0;
    end
    #24 cs_n_out = 1'b1;
    #48;
  endtask : frame
endmodule : spf_host
`default_nettype wire

// File: spf_protect_core_tb_top.sv
`default_nettype none
`include "spf_defs.svh"
module spf_protect_core_tb_top import spf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     ref_clk_in = 1'b0;
  logic                     srst_in = 1'b1;
  logic                     wp_n = 1'b1;
  spf_core_stat_t           core_stat = '0;
  logic                     cs_n, sck, si, so, so_oe_n;
  logic                     wel_clr, wel_set;
  int                       n_clr = 0;
  int                       n_set = 0;
  logic [7:0]               status;
  logic [`SPF_NUM_SECT-1:0] sect;
  logic [15:0]              rx;
  logic [18:0]              sect_addr [11] = '{19'h00000, 19'h10000, 19'h20000, 19'h30000,
    19'h40000, 19'h50000, 19'h60000, 19'h70000, 19'h78000, 19'h7a000, 19'h7c000};
  int                       fails = 0;
  int                       n_checks = 0;
  int                       cyc = 0;
  spf_protect_core dut (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .cs_n_in(cs_n),
    .sck_in(sck), .si_in(si), .wp_n_in(wp_n), .core_stat_in(core_stat), .so_out(so),
    .so_oe_n_out(so_oe_n), .wel_clr_out(wel_clr), .wel_set_out(wel_set), .status_out(status),
    .sect_prot_out(sect));
  spf_host host (.so_in(so), .so_oe_n_in(so_oe_n), .cs_n_out(cs_n), .sck_out(sck),
    .si_out(si));
  always #2 ref_clk_in = ~ref_clk_in;
  // Pulses are counted on the falling edge, half a cycle after launch, so they are settled
  always @(negedge ref_clk_in)
  begin
    if (wel_clr === 1'b1)
      n_clr++;
    if (wel_set === 1'b1)
      n_set++;
  end
  task automatic close_out();
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      close_out();
    end
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic cmd(input logic [31:0] tx, input int ntx, input int nrx);
    @(negedge ref_clk_in);
    host.frame(tx, ntx, nrx, rx);
  endtask : cmd
  task automatic do_reset();
    srst_in = 1'b1;
    repeat (12) @(negedge ref_clk_in);
    srst_in = 1'b0;
    repeat (4) @(negedge ref_clk_in);
  endtask : do_reset
  initial
  begin
    do_reset();
    cmd(32'h05, 8, 16);
    check("status reset", 16'h1c1c, rx);
    core_stat = 3'b111;
    fork
      cmd(32'h05, 8, 16);
      begin
        @(negedge ref_clk_in);
        #776 core_stat.busy = 1'b0;
      end
    join
    check("status refresh", 16'h5f5e, rx);
    core_stat = 3'b001;
    cmd({8'h3c, 24'h0}, 32, 16);
    check("readback s0", 16'hffff, rx);
    cmd({8'h39, 24'h030000}, 32, 0);
    wp_n = 1'b0;
    cmd({8'h3c, 24'h031234}, 32, 16);
    check("readback s3", 16'h0000, rx);
    cmd(32'h05, 8, 8);
    check("status pin low", 16'h0006, rx);
    core_stat.write_enable_latch = 1'b0;
    cmd({8'h39, 24'h040000}, 32, 0);
    check("no latch", 16'h1, 16'(sect[4]));
    core_stat.write_enable_latch = 1'b1;
    wp_n = 1'b1;
    cmd(32'h01ff, 16, 0);
    cmd(32'h05, 8, 8);
    check("status locked", 16'h0096, rx);
    cmd({8'h36, 24'h030000}, 32, 0);
    wp_n = 1'b0;
    cmd(32'h0100, 16, 0);
    cmd({8'h39, 24'h000000}, 32, 0);
    check("locked sectors", 16'h07f7, 16'(sect));
    check("hw lock", 16'h1, 16'(status[7]));
    do_reset();
    check("after reset status", 16'h000e, 16'(status));
    check("after reset sectors", 16'h07ff, 16'(sect));
    wp_n = 1'b1;
    cmd(32'h0180, 16, 0);
    cmd(32'h0100, 16, 0);
    check("lock cleared", 16'h0, 16'(status[7]));
    foreach (sect_addr[i])
      cmd({8'h39, 5'h0, sect_addr[i]}, 32, 0);
    check("all clear", 16'h0, 16'({status[3:2], sect}));
    cmd({8'h3c, 24'h0}, 32, 3);
    check("readback cut", 16'h0, rx);
    check("released", 16'h1, 16'(so_oe_n));
    check("latch clears", 16'd19, 16'(n_clr));
    cmd(32'h06, 8, 0);
    check("latch set", 16'd1, 16'(n_set));
    close_out();
  end
endmodule : spf_protect_core_tb_top
`default_nettype wire
